// ### rtl/ctg_pkg.sv
/*
  shared constants, register map and carrier types of the common-start
  time capture and grouping block.
  assumes a 50 MHz core clock and an AHB-Lite register port on that clock.
*/
package ctg_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PS       = 20000;
  localparam int BIN_PS       = 100;
  localparam logic [31:0] BINS_PER_CLK = 32'(CLK_PS / BIN_PS);
  localparam int DLY_STEP_PS  = 200;
  localparam int DLY_MAX_PS   = 204600;
  localparam int DLY_DEPTH    = (DLY_MAX_PS + CLK_PS - 1) / CLK_PS;
  localparam int DLY_IW       = $clog2(DLY_DEPTH);
  localparam int TPG_LAT_PS   = 95000;
  localparam int TPG_LAT      = (TPG_LAT_PS / CLK_PS < 1) ? 1 : TPG_LAT_PS / CLK_PS;

  // ==========================================================
  // sizes and reset values
  localparam int N_IN   = 5;
  localparam int N_STOP = 4;
  localparam logic [12:0] MAX_HITS    = 13'h1F40;
  localparam logic [31:0] AT_M_RST    = 32'h0000_F424;
  localparam logic [4:0]  AT_N_RST    = 5'h00;
  localparam logic [31:0] LFSR_SEED   = 32'h0000_0001;
  localparam logic [31:0] STD_LIMIT   = 32'h0100_0000;
  localparam logic [31:0] EXT_LIMIT   = 32'h8000_0000;
  localparam logic        CONT_AVAIL  = 1'b1;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_EDGE     = 8'h04;
  localparam logic [7:0] ADDR_AT_M     = 8'h08;
  localparam logic [7:0] ADDR_AT_N     = 8'h0C;
  localparam logic [7:0] ADDR_WIN_BASE = 8'h10;
  localparam logic [7:0] ADDR_DLY_BASE = 8'h20;
  localparam logic [7:0] ADDR_TPG_BASE = 8'h34;
  localparam logic [7:0] ADDR_STATUS   = 8'h48;

  localparam int CTRL_CAPTURE = 0;
  localparam int CTRL_GROUP   = 1;
  localparam int CTRL_EXT     = 2;
  localparam int CTRL_CONT    = 3;
  localparam int CTRL_INIT    = 4;
  localparam int EDGE_START_FALL = 8;
  localparam int TPG_DRIVE    = 8;
  localparam logic [31:0] TPG_WMASK = 32'h00FF_013F;

  // ==========================================================
  // types
  typedef enum logic [1:0] {CI_OFF, CI_GREEN, CI_YELLOW, CI_RED} ctg_ind_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ctg_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ctg_ahb_rsp_t;

  typedef struct packed {
    logic        is_start;
    logic [3:0]  rise;
    logic [3:0]  fall;
    logic [30:0] rel;
    logic [63:0] abs;
  } ctg_word_t;

  typedef struct packed {
    logic      valid;
    ctg_word_t word;
  } ctg_pkt_t;

  typedef struct packed {
    logic [4:0]                     ctrl;
    logic [8:0]                     edge_en;
    logic [31:0]                    at_m;
    logic [4:0]                     at_n;
    logic [3:0][31:0]               win;
    logic [4:0][9:0]                dly;
    logic [4:0][31:0]               tpg;
    logic                           wr_pend;
    logic [7:0]                     addr;
    logic [31:0]                    hrdata;
    logic [4:0]                     sync1;
    logic [4:0]                     sync2;
    logic [4:0]                     prev;
    logic [4:0][DLY_DEPTH-1:0]      sr;
    logic [63:0]                    abs_ts;
    logic [30:0]                    rel;
    logic                           grp_open;
    logic [12:0]                    hit_cnt;
    logic [31:0]                    lfsr;
    logic [31:0]                    at_cnt;
    logic [4:0][TPG_LAT-1:0]        lat;
    logic [4:0][7:0]                pcnt;
    logic [4:0]                     tpg_out;
    logic                           out_valid;
    ctg_word_t                      out_word;
    logic                           lost;
    logic                           seen_start;
    ctg_ind_t                       ind;
  } ctg_state_t;

  // byte address of the idx-th word of a register array
  function automatic logic [7:0] reg_at(input logic [7:0] base, input int idx);
    reg_at = 8'(int'(base) + idx * 4);
  endfunction

endpackage

// ### rtl/ctg_top.sv
/*
  common-start time capture with grouping, auto-trigger, input delay and
  connector pattern generators; packets leave on a valid/ready word port.
  assumes connector inputs are asynchronous, the register master is
  AHB-Lite on sys_clk and the packet sink may stall at any time.
*/
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module ctg_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire ctg_pkg::ctg_ahb_req_t ahb_req,
  output      ctg_pkg::ctg_ahb_rsp_t ahb_rsp,
  input  wire logic [4:0]            conn_in,
  output      logic [4:0]            conn_out,
  output      logic [4:0]            conn_oe,
  output      ctg_pkg::ctg_pkt_t     pkt,
  input  wire logic                  pkt_ready,
  output      ctg_pkg::ctg_ind_t     capture_indicator,
  output      logic                  init_indicator
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] popcnt8(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int b = 0; b < 8; b++) begin
      c = c + 4'(v[b]);
    end
    popcnt8 = c;
  endfunction

  // delay steps to a tap of the per-input shift register
  function automatic logic [ctg_pkg::DLY_IW-1:0] dly_tap(input logic [9:0] steps);
    dly_tap = ctg_pkg::DLY_IW'(int'(steps) * ctg_pkg::DLY_STEP_PS / ctg_pkg::CLK_PS);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input ctg_pkg::ctg_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == ctg_pkg::ADDR_CTRL) begin
      r = 32'(s.ctrl);
    end
    if (a == ctg_pkg::ADDR_EDGE) begin
      r = 32'(s.edge_en);
    end
    if (a == ctg_pkg::ADDR_AT_M) begin
      r = s.at_m;
    end
    if (a == ctg_pkg::ADDR_AT_N) begin
      r = 32'(s.at_n);
    end
    for (int i = 0; i < ctg_pkg::N_STOP; i++) begin
      if (a == ctg_pkg::reg_at(ctg_pkg::ADDR_WIN_BASE, i)) begin
        r = s.win[i];
      end
    end
    for (int i = 0; i < ctg_pkg::N_IN; i++) begin
      if (a == ctg_pkg::reg_at(ctg_pkg::ADDR_DLY_BASE, i)) begin
        r = 32'(s.dly[i]);
      end
      if (a == ctg_pkg::reg_at(ctg_pkg::ADDR_TPG_BASE, i)) begin
        r = s.tpg[i];
      end
    end
    if (a == ctg_pkg::ADDR_STATUS) begin
      r = {12'h000, s.lost, s.seen_start, s.ind, s.grp_open, s.out_valid, 1'b0, s.hit_cnt};
    end
    reg_read = r;
  endfunction

  // ==========================================================
  // state
  ctg_pkg::ctg_state_t q;
  ctg_pkg::ctg_state_t d;

  logic [4:0]   dval;
  logic [4:0]   rise;
  logic [4:0]   fall;
  logic [31:0]  rnd;
  logic         at_fire;
  logic         cap;
  logic         cont;
  logic         start_ev;
  logic [30:0]  cur_rel;
  logic [31:0]  nxt_rel;
  logic         ovf;
  logic [15:0]  max_close;
  logic [3:0]   in_win;
  logic         acc;
  logic [3:0]   hr;
  logic [3:0]   hf;
  logic [12:0]  hbase;
  logic [12:0]  hsum;
  logic [3:0]   pc;
  logic         emit;
  logic         trig;
  logic         accept;
  ctg_pkg::ctg_word_t word;

  always_comb begin
    d = q;
    trig = 1'b0;

    // ==========================================================
    // register writes, data phase of the previous accepted write
    if (q.wr_pend) begin
      if (q.addr == ctg_pkg::ADDR_CTRL) begin
        d.ctrl = ahb_req.hwdata[4:0];
      end
      if (q.addr == ctg_pkg::ADDR_EDGE) begin
        d.edge_en = ahb_req.hwdata[8:0];
      end
      if (q.addr == ctg_pkg::ADDR_AT_M) begin
        d.at_m = ahb_req.hwdata;
      end
      if (q.addr == ctg_pkg::ADDR_AT_N) begin
        d.at_n = ahb_req.hwdata[4:0];
      end
      for (int i = 0; i < ctg_pkg::N_STOP; i++) begin
        if (q.addr == ctg_pkg::reg_at(ctg_pkg::ADDR_WIN_BASE, i)) begin
          d.win[i] = ahb_req.hwdata;
        end
      end
      for (int i = 0; i < ctg_pkg::N_IN; i++) begin
        if (q.addr == ctg_pkg::reg_at(ctg_pkg::ADDR_DLY_BASE, i)) begin
          d.dly[i] = ahb_req.hwdata[9:0];
        end
        if (q.addr == ctg_pkg::reg_at(ctg_pkg::ADDR_TPG_BASE, i)) begin
          d.tpg[i] = ahb_req.hwdata & ctg_pkg::TPG_WMASK;
        end
      end
    end

    // address phase; read data taken from the updated copy
    accept = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    d.wr_pend = 1'b0;
    if (accept) begin
      d.addr = (ahb_req.haddr[31:8] == 24'h00_0000) ? ahb_req.haddr[7:0] : 8'hFF;
      d.wr_pend = ahb_req.hwrite;
      if (!ahb_req.hwrite) begin
        d.hrdata = reg_read(d.addr, d);
      end
    end

    // ==========================================================
    // input synchronisers and delay lines
    d.sync1 = conn_in;
    d.sync2 = q.sync1;
    for (int i = 0; i < ctg_pkg::N_IN; i++) begin
      d.sr[i] = {q.sr[i][ctg_pkg::DLY_DEPTH-2:0], q.sync2[i]};
      dval[i] = q.sr[i][dly_tap(q.dly[i])];
    end
    d.prev = dval;
    rise = dval & ~q.prev;
    fall = ~dval & q.prev;

    // ==========================================================
    // auto-trigger
    // free-running LFSR
    d.lfsr = {q.lfsr[30:0], q.lfsr[31] ^ q.lfsr[21] ^ q.lfsr[1] ^ q.lfsr[0]};
    rnd = q.lfsr & ((32'h0000_0001 << q.at_n) - 32'h0000_0001);
    at_fire = (q.at_cnt == 32'h0000_0000);
    if (at_fire) begin
      d.at_cnt = q.at_m + rnd - 32'h0000_0001;
    end else begin
      d.at_cnt = q.at_cnt - 32'h0000_0001;
    end

    // ==========================================================
    // capture and grouping
    cap = q.ctrl[ctg_pkg::CTRL_CAPTURE];
    cont = q.ctrl[ctg_pkg::CTRL_CONT] & ctg_pkg::CONT_AVAIL;
    if (cont) begin
      start_ev = cap & at_fire;
    end else if (q.edge_en[ctg_pkg::EDGE_START_FALL]) begin
      start_ev = cap & fall[0];
    end else begin
      start_ev = cap & rise[0];
    end

    d.abs_ts = q.abs_ts + 64'(ctg_pkg::BINS_PER_CLK);
    cur_rel = start_ev ? 31'h0000_0000 : q.rel;
    nxt_rel = {1'b0, cur_rel} + ctg_pkg::BINS_PER_CLK;
    if (q.ctrl[ctg_pkg::CTRL_EXT]) begin
      ovf = (nxt_rel >= ctg_pkg::EXT_LIMIT);
      d.rel = nxt_rel[30:0];
    end else begin
      ovf = (nxt_rel >= ctg_pkg::STD_LIMIT);
      d.rel = {7'h00, nxt_rel[23:0]};
    end

    max_close = 16'h0000;
    for (int c = 0; c < ctg_pkg::N_STOP; c++) begin
      if (q.win[c][31:16] > max_close) begin
        max_close = q.win[c][31:16];
      end
      in_win[c] = !q.ctrl[ctg_pkg::CTRL_GROUP] | cont |
                  ((cur_rel >= 31'(q.win[c][15:0])) && (cur_rel <= 31'(q.win[c][31:16])));
    end

    d.grp_open = cap & (start_ev | q.grp_open);
    if (!cont && (ovf || (q.ctrl[ctg_pkg::CTRL_GROUP] && nxt_rel > 32'(max_close)))) begin
      d.grp_open = 1'b0;
    end

    acc = cap & (start_ev | q.grp_open);
    hr = rise[4:1] & q.edge_en[3:0] & in_win & {4{acc}};
    hf = fall[4:1] & q.edge_en[7:4] & in_win & {4{acc}};

    hbase = start_ev ? 13'h0000 : q.hit_cnt;
    pc = popcnt8({hr, hf});
    hsum = hbase + 13'(pc);
    if (hsum > ctg_pkg::MAX_HITS) begin
      hr = 4'h0;
      hf = 4'h0;
      hsum = hbase;
    end
    d.hit_cnt = hsum;

    word.is_start = start_ev;
    word.rise = hr;
    word.fall = hf;
    word.rel = cur_rel;
    word.abs = q.abs_ts;
    emit = start_ev | (|hr) | (|hf);

    // ==========================================================
    // output word, one register stage; a stalled sink loses data
    if (q.out_valid & pkt_ready) begin
      d.out_valid = 1'b0;
    end
    if (emit) begin
      if (q.out_valid & !pkt_ready) begin
        d.lost = 1'b1;
      end else begin
        d.out_valid = 1'b1;
        d.out_word = word;
      end
    end

    if (!cap) begin
      d.lost = 1'b0;
      d.seen_start = 1'b0;
      d.ind = ctg_pkg::CI_OFF;
    end else begin
      d.seen_start = q.seen_start | start_ev;
      if (d.lost) begin
        d.ind = ctg_pkg::CI_RED;
      end else if (d.seen_start) begin
        d.ind = ctg_pkg::CI_YELLOW;
      end else begin
        d.ind = ctg_pkg::CI_GREEN;
      end
    end

    // ==========================================================
    // connector pattern generators
    for (int k = 0; k < ctg_pkg::N_IN; k++) begin
      trig = |(q.tpg[k][5:0] & {at_fire, rise});
      if (ctg_pkg::TPG_LAT > 1) begin
        d.lat[k] = {q.lat[k][ctg_pkg::TPG_LAT-2:0], trig};
      end else begin
        d.lat[k] = ctg_pkg::TPG_LAT'(trig);
      end
      if (q.lat[k][ctg_pkg::TPG_LAT-1]) begin
        d.pcnt[k] = q.tpg[k][23:16];
      end else if (q.pcnt[k] != 8'h00) begin
        d.pcnt[k] = q.pcnt[k] - 8'h01;
      end
      d.tpg_out[k] = (d.pcnt[k] != 8'h00);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q <= '0;
      q.at_m <= ctg_pkg::AT_M_RST;
      q.at_n <= ctg_pkg::AT_N_RST;
      q.at_cnt <= ctg_pkg::AT_M_RST - 32'h0000_0001;
      q.lfsr <= ctg_pkg::LFSR_SEED;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;
  assign ahb_rsp.hrdata = q.hrdata;
  assign pkt.valid = q.out_valid;
  assign pkt.word = q.out_word;
  assign capture_indicator = q.ind;
  assign init_indicator = q.ctrl[ctg_pkg::CTRL_INIT];
  for (genvar k = 0; k < ctg_pkg::N_IN; k++) begin : g_conn
    assign conn_oe[k] = q.tpg[k][ctg_pkg::TPG_DRIVE];
    assign conn_out[k] = q.tpg_out[k];
  end

endmodule

// ### bench/ctg_asserts.sv
/*
  port checker for ctg_top: bus answer, packet hold, word contents,
  indicators and connector enables.
  assumes the only bus master runs on sys_clk; bound onto ctg_top below.
*/
`timescale 1ns/100ps
module ctg_asserts (
  input wire logic                  sys_clk,
  input wire logic                  rstn,
  input wire ctg_pkg::ctg_ahb_req_t ahb_req,
  input wire ctg_pkg::ctg_ahb_rsp_t ahb_rsp,
  input wire ctg_pkg::ctg_pkt_t     pkt,
  input wire logic                  pkt_ready,
  input wire logic [4:0]            conn_oe,
  input wire ctg_pkg::ctg_ind_t     capture_indicator,
  input wire logic                  init_indicator
);
  // ==========================================================
  // shadow of control and drive bits, rebuilt from observed writes
  logic       wr_q;
  logic [7:0] wa_q;
  logic [4:0] ctrl_q;
  logic [4:0] drv_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_q   <= 1'b0;
      wa_q   <= 8'h00;
      ctrl_q <= 5'h00;
      drv_q  <= 5'h00;
    end else begin
      wr_q <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite
              && ahb_req.haddr[31:8] == 24'h00_0000;
      wa_q <= ahb_req.haddr[7:0];
      if (wr_q && wa_q == 8'h00) begin
        ctrl_q <= ahb_req.hwdata[4:0];
      end
      for (int i = 0; i < 5; i++) begin
        if (wr_q && wa_q == 8'h34 + 8'(4 * i)) begin
          drv_q[i] <= ahb_req.hwdata[8];
        end
      end
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  bus_ok_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
    else $error("bus answer not ready or not okay");
  rst_quiet_a: assert property (disable iff (1'b0) !rstn |=>
    !pkt.valid && conn_oe == 5'h00 && !init_indicator)
    else $error("outputs active after reset edge");
  pkt_hold_a: assert property (pkt.valid && !pkt_ready |=> pkt.valid && $stable(pkt.word))
    else $error("packet word changed before it was taken");
  hdr_rel_a: assert property (pkt.valid && pkt.word.is_start && !ctrl_q[3] |->
    pkt.word.rel == 31'h0000_0000)
    else $error("group header not at zero");
  word_hits_a: assert property (pkt.valid && !pkt.word.is_start |->
    (pkt.word.rise | pkt.word.fall) != 4'h0)
    else $error("hit word without a hit");
  std_range_a: assert property (pkt.valid && ctrl_q[3:2] == 2'b00 |->
    pkt.word.rel[30:24] == 7'h00)
    else $error("stamp wider than standard range");
  bin_quant_a: assert property (pkt.valid && !ctrl_q[3] |-> pkt.word.rel % 200 == 0)
    else $error("stamp not whole clock of bins");
  init_ind_a: assert property ($stable(ctrl_q) [*3] |-> init_indicator == ctrl_q[4])
    else $error("init indicator disagrees with control");
  cap_off_a: assert property ($stable(ctrl_q) [*3] ##0 !ctrl_q[0] |->
    capture_indicator == ctg_pkg::CI_OFF)
    else $error("capture indicator lit while idle");
  oe_follow_a: assert property ($stable(drv_q) [*3] |-> conn_oe == drv_q)
    else $error("connector enable disagrees with drive bit");
endmodule

bind ctg_top ctg_asserts chk_u (
  .sys_clk          (sys_clk),
  .rstn             (rstn),
  .ahb_req          (ahb_req),
  .ahb_rsp          (ahb_rsp),
  .pkt              (pkt),
  .pkt_ready        (pkt_ready),
  .conn_oe          (conn_oe),
  .capture_indicator(capture_indicator),
  .init_indicator   (init_indicator)
);

// ### bench/ctg_host_model.sv
/*
  packet sink standing for the host: collects every word taken.
  assumes the bench raises stall to make it slow; ready follows a clock late.
*/
`timescale 1ns/100ps
module ctg_host_model (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire ctg_pkg::ctg_pkt_t pkt,
  input  wire logic              stall,
  output      logic              pkt_ready = 1'b0
);
  ctg_pkg::ctg_word_t got[$];

  // ==========================================================
  // sink: a word counts as taken only at an edge with valid and ready
  always @(posedge sys_clk) begin
    if (pkt.valid === 1'b1 && pkt_ready === 1'b1) begin
      got.push_back(pkt.word);
    end
    pkt_ready <= rstn && !stall;
  end
endmodule

// ### bench/tb_common_start_tdc_grouping.sv
/*
  bench for ctg_top: registers, capture, grouping, lost data, auto-trigger,
  generators and continuous mode, one task per scenario.
  assumes ctg_host_model as sink and ctg_asserts bound onto the top.
*/
`timescale 1ns/100ps
module tb_common_start_tdc_grouping;
  logic                  sys_clk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  stall = 1'b0;
  logic [4:0]            pin_drv = 5'h00;
  logic [4:0]            conn_in;
  logic [4:0]            conn_out;
  logic [4:0]            conn_oe;
  logic                  pkt_ready;
  logic                  init_ind;
  logic [31:0]           rd;
  ctg_pkg::ctg_ahb_req_t hq = '0;
  ctg_pkg::ctg_ahb_req_t ahb_in;
  ctg_pkg::ctg_ahb_rsp_t rsp;
  ctg_pkg::ctg_pkt_t     pkt;
  ctg_pkg::ctg_ind_t     cap_ind;
  int                    errors = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  assign ahb_in = '{hq.hsel, hq.haddr, hq.htrans, hq.hwrite, hq.hsize, hq.hwdata, rsp.hreadyout};
  // outside drive only on pins the device leaves as inputs
  assign conn_in = (conn_oe & conn_out) | (~conn_oe & pin_drv);

  ctg_top dut_u (.sys_clk, .rstn, .ahb_req(ahb_in), .ahb_rsp(rsp), .conn_in, .conn_out,
    .conn_oe, .pkt, .pkt_ready, .capture_indicator(cap_ind), .init_indicator(init_ind));
  ctg_host_model host_u (.sys_clk, .rstn, .pkt, .stall, .pkt_ready);

  initial forever #10 sys_clk = ~sys_clk;

  // ==========================================================
  // common tasks
  task automatic end_of_test;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard; the first auto-trigger only comes after the 62500-cycle reset period
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 70000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hq <= '{1'b1, {24'h00_0000, a}, 2'b10, w, 3'h2, hq.hwdata, 1'b1};
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    hq.htrans <= 2'b00;
    hq.hwdata <= d;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  // one nibble of s per cycle onto start and stops A to C; then let words drain
  task automatic play(input int n, input logic [63:0] s);
    host_u.got.delete();
    for (int i = 0; i < n; i++) begin
      pin_drv <= {1'b0, s[4*i +: 4]};
      @(posedge sys_clk);
    end
    pin_drv <= 5'h00;
    repeat (14) @(posedge sys_clk);
  endtask

  // cycles until the next rising edge seen on a generator output
  task automatic rise(input int b, output int n);
    logic lo;
    n = 0;
    lo = 1'b0;
    while (!(lo && conn_out[b] === 1'b1)) begin
      lo |= conn_out[b] === 1'b0;
      @(posedge sys_clk);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    bus(8'h08, 1'b0, 32'h0000_0000);
    chk(rd === 32'h0000_F424, "period reset");
    bus(8'h0C, 1'b0, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "exponent reset");
    bus(8'h14, 1'b1, 32'hFFFF_0000);
    bus(8'h14, 1'b0, 32'h0000_0000);
    chk(rd === 32'hFFFF_0000, "window readback");
    bus(8'hFC, 1'b1, 32'h1234_5678);
    bus(8'hFC, 1'b0, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_capture;
    bus(8'h04, 1'b1, 32'h0000_0021);
    bus(8'h00, 1'b1, 32'h0000_0011);
    repeat (3) @(posedge sys_clk);
    chk(init_ind === 1'b1, "init indicator");
    chk(cap_ind === ctg_pkg::CI_GREEN, "not green");
    play(10, 64'h0000_0004_4020_0001);
    chk(cap_ind === ctg_pkg::CI_YELLOW, "not yellow");
    chk(host_u.got.size() == 3, "word count");
    chk(host_u.got[0].is_start === 1'b1 && host_u.got[0].rel === 31'h0000_0000, "hdr");
    chk(host_u.got[1].rise === 4'h1 && host_u.got[1].rel === 31'h0000_03E8, "rise A");
    chk(host_u.got[2].fall === 4'h2 && host_u.got[2].rel === 31'h0000_0708, "fall B");
  endtask

  task automatic t_group;
    // window A opens at 400 bins and closes at 1000
    bus(8'h10, 1'b1, 32'h03E8_0190);
    // extended range set too: short groups must look the same in it
    bus(8'h00, 1'b1, 32'h0000_0017);
    play(14, 64'h0002_0000_2001_2021);
    chk(host_u.got.size() == 4, "group words");
    chk(host_u.got[1].rel === 31'h0000_0258, "in window");
    chk(host_u.got[2].is_start === 1'b1, "second header");
    chk(host_u.got[3].rel === 31'h0000_0258, "new group");
  endtask

  task automatic t_lost;
    stall <= 1'b1;
    // stop A three clocks after start falls inside window A, so it must be dropped
    play(6, 64'h0000_0000_0000_2001);
    chk(pkt.valid === 1'b1 && pkt.word.is_start === 1'b1, "held header");
    chk(cap_ind === ctg_pkg::CI_RED, "not red");
    bus(8'h48, 1'b0, 32'h0000_0000);
    chk(rd[19] === 1'b1 && rd[17:16] === 2'b11 && rd[14] === 1'b1, "status lost");
    stall <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(8'h00, 1'b1, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk(cap_ind === ctg_pkg::CI_OFF && init_ind === 1'b0, "indicators off");
  endtask

  task automatic t_auto;
    int n;
    int mn;
    int mx;
    int l0;
    bus(8'h08, 1'b1, 32'h0000_0008);
    // generator 0: auto source, drives its pin, two cycle pulse
    bus(8'h34, 1'b1, 32'h0002_0120);
    repeat (3) @(posedge sys_clk);
    chk(conn_oe === 5'h01, "drive enable");
    rise(0, n);
    rise(0, n);
    chk(n == 8, "fixed period");
    @(posedge sys_clk);
    chk(conn_out[0] === 1'b1, "width high");
    @(posedge sys_clk);
    chk(conn_out[0] === 1'b0, "width end");
    bus(8'h0C, 1'b1, 32'h0000_0003);
    rise(0, n);
    mn = 99;
    mx = 0;
    for (int i = 0; i < 8; i++) begin
      rise(0, n);
      chk(n >= 8 && n <= 15, "random period range");
      mn = n < mn ? n : mn;
      mx = n > mx ? n : mx;
    end
    chk(mx != mn, "period never varies");
    // generator 1 fires on the start pin, which carries generator 0
    bus(8'h38, 1'b1, 32'h0001_0101);
    rise(0, n);
    rise(1, n);
    chk(n >= 3 && n <= 10, "input latency");
    l0 = n;
    // period longer than the delayed path, so one pulse cannot overtake the next
    bus(8'h08, 1'b1, 32'h0000_0020);
    bus(8'h0C, 1'b1, 32'h0000_0000);
    // 500 steps of 200 ps hold the start input back five clocks
    bus(8'h20, 1'b1, 32'h0000_01F4);
    rise(0, n);
    rise(0, n);
    rise(1, n);
    chk(n == l0 + 5, "input delay");
    bus(8'h08, 1'b1, 32'h0000_0008);
    bus(8'h34, 1'b1, 32'h0000_0000);
    bus(8'h38, 1'b1, 32'h0000_0000);
  endtask

  task automatic t_cont;
    logic [63:0] h[$];
    host_u.got.delete();
    bus(8'h00, 1'b1, 32'h0000_0019);
    repeat (60) @(posedge sys_clk);
    bus(8'h00, 1'b1, 32'h0000_0000);
    foreach (host_u.got[i]) begin
      if (host_u.got[i].is_start === 1'b1) h.push_back(host_u.got[i].abs);
    end
    chk(h.size() >= 3, "periodic headers");
    chk(h[2] - h[1] === 64'h0000_0000_0000_0640, "header spacing");
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_capture();
    t_group();
    t_lost();
    t_auto();
    t_cont();
    end_of_test();
  end
endmodule
